// File: logic/dzc_ctl.sv
// controller end: schedules calibration, refresh and self-refresh
//
// Functional notes
// - overlapping entry/exit: termination response uncertain
// - exit-then-entry overlap: also uncertain
// - long calibration at init; device runs engine
// - first long gets init window, later oper
// - short calibration gets short window
// - channel quiet during any calibration window
// - device turns calibration current off after
// - precharge all and wait before calibrating
// - no calibration after self-refresh without command
// - wait exit time before calibrating after self-refresh
// - shared resistor: rank windows never overlap
// - keep clock enable high while calibrating
// - termination off during calibration
// - all data drivers off during calibration
// - refresh cycle time by density before next
// - extended temperature halves refresh interval, except for a part specified for 1x refresh
// - extended self-refresh needs proper mode bits
// - transition begins write latency minus one
`timescale 1ns/10ps
`default_nettype none
module dzc_ctl
	import dzc_pkg::*;
#(
	parameter int NRANK = 2,	// ranks sharing one resistor
	parameter int WL    = 5	// write latency in clocks
)
(
	input  wire logic  CLK_IN,	// command clock
	input  wire logic  RESET_N_IN,	// async reset, active low
	dzc_link_if.ctl    LINK,	// command link
	input  wire logic  ZQCS_REQ_IN,	// request periodic short calibration
	input  wire logic  SRE_REQ_IN,	// request self-refresh entry
	input  wire logic  SRX_REQ_IN,	// request self-refresh exit
	input  wire logic  EXT_TEMP_IN,	// extended temperature range
	input  wire logic  REF1X_IN,	// part specified for 1x refresh
	input  wire logic  ASR_IN,	// use automatic self-refresh
	input  wire logic  PD_REQ_IN,	// request power-down
	input  wire logic  ODT_REQ_IN,	// user termination request
	input  wire logic  DQ_OE_REQ_IN,	// user wants to drive data
	input  wire logic  [1:0] DENSITY_IN,	// dzc_den_type code
	output var logic   BUSY_OUT,	// calibration window open
	output var logic   INIT_DONE_OUT,	// init calibration finished
	output var logic   ODT_UNCERTAIN_OUT	// termination timing uncertain
);
	typedef enum {ST_PREA, ST_TRP, ST_ZQ, ST_WAIT, ST_IDLE, ST_TRFC, ST_SREF, ST_TXS} dzc_st_type;

	localparam int RW = (NRANK > 1) ? $clog2(NRANK) : 1;
	localparam logic [CNT_W-1:0] ANPD = CNT_W'(WL - 1);

	// refresh cycle time per density
	function automatic logic [CNT_W-1:0] trfc(input logic [1:0] d);
		case (dzc_den_type'(d))
			DZC_DEN_1G: return CNT_W'(TRFC1_CYC);
			DZC_DEN_4G: return CNT_W'(TRFC4_CYC);
			default:    return CNT_W'(TRFC2_CYC);
		endcase
	endfunction : trfc

	dzc_st_type       st, next_st;	// scheduler state
	logic [CNT_W-1:0] wait_cnt, next_wait_cnt;	// shared window counter
	logic [CNT_W-1:0] refi, next_refi;	// refresh interval counter
	logic [RW-1:0]    rk, next_rk;	// rank being calibrated
	logic [NRANK-1:0] first, next_first;	// per-rank first long done
	logic             init, next_init;	// initial calibration finished
	logic [CNT_W-1:0] pd_win, next_pd_win;	// transition window counter
	logic             pd_q, next_pd_q;	// registered power-down request
	dzc_cmd_type      cmd;	// command this cycle
	logic [7:0]       mr2;	// mode 2 value with self-refresh entry

	// scheduler next state
	always_comb
	begin
		next_st       = st;
		next_wait_cnt = (wait_cnt != '0) ? wait_cnt - CNT_W'(1) : wait_cnt;
		next_refi     = (refi != '0) ? refi - CNT_W'(1) : refi;
		next_rk       = rk;
		next_first    = first;
		next_init     = init;
		cmd           = DZC_CMD_NOP;
		mr2           = '0;
		case (st)
			ST_PREA:
			begin
				// close every bank before calibrating
				cmd           = DZC_CMD_PREA;
				next_wait_cnt = CNT_W'(TRP_CYC);
				next_st       = ST_TRP;
			end
			ST_TRP:
				if (wait_cnt <= CNT_W'(1))
					next_st = ST_ZQ;
			ST_ZQ:
			begin
				// one rank at a time, long until every rank has had its first
				cmd = init ? DZC_CMD_ZQCS : DZC_CMD_ZQCL;
				if (!init)
					next_wait_cnt = first[rk] ? CNT_W'(TZQOPER_CYC) : CNT_W'(TZQINIT_CYC);
				else
					next_wait_cnt = CNT_W'(TZQCS_CYC);
				next_first[rk] = 1'b1;
				next_st = ST_WAIT;
			end
			ST_WAIT:
				// quiet channel until the window ends; next rank only after
				if (wait_cnt <= CNT_W'(1))
				begin
					if (32'(rk) == NRANK - 1)
					begin
						next_rk   = '0;
						next_init = 1'b1;
						next_st   = ST_IDLE;
					end
					else
					begin
						next_rk = rk + RW'(1);
						next_st = ST_ZQ;
					end
				end
			ST_IDLE:
				// issue on the last counted cycle so the gap is the interval, not one more
				if (refi <= CNT_W'(1))
				begin
					// refresh due
					cmd           = DZC_CMD_REF;
					next_wait_cnt = trfc(DENSITY_IN);
					next_refi     = (EXT_TEMP_IN && !REF1X_IN) ?
						CNT_W'(TREFI_EXT_CYC) : CNT_W'(TREFI_NORM_CYC);
					next_st       = ST_TRFC;
				end
				else if (SRE_REQ_IN)
				begin
					cmd = DZC_CMD_SRE;
					// manual extended or automatic self-refresh
					mr2[MR2_ASR_BIT] = ASR_IN;
					mr2[MR2_SRT_BIT] = EXT_TEMP_IN && !ASR_IN;
					next_st = ST_SREF;
				end
				else if (ZQCS_REQ_IN)
					next_st = ST_PREA;
			ST_TRFC:
				if (wait_cnt <= CNT_W'(1))
					next_st = ST_IDLE;
			ST_SREF:
				if (SRX_REQ_IN)
				begin
					cmd           = DZC_CMD_SRX;
					next_wait_cnt = CNT_W'(TXS_CYC);
					next_st       = ST_TXS;
				end
			ST_TXS:
				// device will not recalibrate by itself: ask for a short one
				if (wait_cnt <= CNT_W'(1))
					next_st = ST_PREA;
			default:
				next_st = ST_PREA;
		endcase
	end

	// calibration window open
	logic cal_win;
	assign cal_win = (st == ST_ZQ) || (st == ST_WAIT);

	// power-down transition tracking: uncertainty spans overlapping windows
	always_comb
	begin
		next_pd_q  = PD_REQ_IN && (st == ST_IDLE);
		next_pd_win = (pd_win != '0) ? pd_win - CNT_W'(1) : pd_win;
		// any clock-enable change reopens the window: entry and exit merge
		if (next_pd_q != pd_q)
			next_pd_win = ANPD + ANPD;
	end

	// state registers
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			st       <= ST_PREA;
			wait_cnt <= '0;
			refi     <= CNT_W'(TREFI_NORM_CYC);
			rk       <= '0;
			first    <= '0;
			init     <= 1'b0;
			pd_win   <= '0;
			pd_q     <= 1'b0;
		end
		else
		begin
			st       <= next_st;
			wait_cnt <= next_wait_cnt;
			refi     <= next_refi;
			rk       <= next_rk;
			first    <= next_first;
			init     <= next_init;
			pd_win   <= next_pd_win;
			pd_q     <= next_pd_q;
		end
	end

	// link and status outputs, all registered
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			LINK.cmd          <= DZC_CMD_NOP;
			LINK.rank         <= 1'b0;
			LINK.cke          <= 1'b1;
			LINK.odt          <= 1'b0;
			LINK.dq_oe_ctl    <= 1'b0;
			LINK.mr2          <= '0;
			BUSY_OUT          <= 1'b0;
			INIT_DONE_OUT     <= 1'b0;
			ODT_UNCERTAIN_OUT <= 1'b0;
		end
		else
		begin
			LINK.cmd          <= cmd;
			LINK.rank         <= rk[0];
			LINK.cke          <= !next_pd_q || cal_win;
			LINK.odt          <= ODT_REQ_IN && !cal_win;
			LINK.dq_oe_ctl    <= DQ_OE_REQ_IN && !cal_win && (st == ST_IDLE);
			LINK.mr2          <= mr2;
			BUSY_OUT          <= cal_win;
			INIT_DONE_OUT     <= init;
			ODT_UNCERTAIN_OUT <= next_pd_win != '0;
		end
	end
endmodule : dzc_ctl
`default_nettype wire

// File: include/dzc_pkg.sv
// shared constants and types for the calibration and refresh command link
package dzc_pkg;

	// command clock
	localparam int CLK_PERIOD_PS = 4000;	// 250 MHz

	// calibration windows in ns; plain defaults
	localparam int TZQINIT_NS = 2048;	// first long calibration after reset
	localparam int TZQOPER_NS = 1024;	// later long calibration
	localparam int TZQCS_NS   = 256;	// short calibration
	localparam int TRP_NS     = 15;	// precharge to calibration
	localparam int TXS_NS     = 170;	// self-refresh exit to calibration

	// refresh cycle time per density, ns
	localparam int TRFC_1G_NS = 110;
	localparam int TRFC_2G_NS = 160;
	localparam int TRFC_4G_NS = 260;

	// refresh interval, ns (normal and extended temperature)
	localparam int TREFI_NORM_NS = 7800;
	localparam int TREFI_EXT_NS  = 3900;

	// ns to cycles, rounding up, never below one
	function automatic int dzc_cyc(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : dzc_cyc

	localparam int TZQINIT_CYC = dzc_cyc(TZQINIT_NS);
	localparam int TZQOPER_CYC = dzc_cyc(TZQOPER_NS);
	localparam int TZQCS_CYC   = dzc_cyc(TZQCS_NS);
	localparam int TRP_CYC     = dzc_cyc(TRP_NS);
	localparam int TXS_CYC     = dzc_cyc(TXS_NS);
	localparam int TRFC1_CYC   = dzc_cyc(TRFC_1G_NS);
	localparam int TRFC2_CYC   = dzc_cyc(TRFC_2G_NS);
	localparam int TRFC4_CYC   = dzc_cyc(TRFC_4G_NS);
	localparam int TREFI_NORM_CYC = dzc_cyc(TREFI_NORM_NS);
	localparam int TREFI_EXT_CYC  = dzc_cyc(TREFI_EXT_NS);

	localparam int CNT_W = 14;	// wide enough for every window

	// mode register 2 temperature fields
	localparam int MR2_ASR_BIT = 6;
	localparam int MR2_SRT_BIT = 7;

	// commands on the link
	typedef enum logic [2:0]
	{
		DZC_CMD_NOP,
		DZC_CMD_ZQCL,
		DZC_CMD_ZQCS,
		DZC_CMD_REF,
		DZC_CMD_ACT,
		DZC_CMD_PREA,
		DZC_CMD_SRE,
		DZC_CMD_SRX
	} dzc_cmd_type;

	// density selection
	typedef enum logic [1:0]
	{
		DZC_DEN_1G,
		DZC_DEN_2G,
		DZC_DEN_4G
	} dzc_den_type;

endpackage : dzc_pkg

// File: include/dzc_link_if.sv
// command link between the controller and the memory device
`timescale 1ns/10ps
`default_nettype none
interface dzc_link_if;
	import dzc_pkg::*;
	dzc_cmd_type cmd;	// command, one clock
	logic        rank;	// target rank
	logic        cke;	// clock enable
	logic        odt;	// termination request
	logic        dq_oe_ctl;	// controller drives data bus
	logic [7:0]  mr2;	// mode register 2 value with a command

	modport ctl (output cmd, output rank, output cke, output odt, output dq_oe_ctl, output mr2);
	modport dev (input cmd, input rank, input cke, input odt, input dq_oe_ctl, input mr2);
endinterface : dzc_link_if
`default_nettype wire

// File: logic/dzc_dev.sv
// memory device end: calibration engine and self-refresh state
`timescale 1ns/10ps
`default_nettype none
module dzc_dev
	import dzc_pkg::*;
(
	input  wire logic  CLK_IN,	// command clock
	input  wire logic  RESET_N_IN,	// async reset, active low
	dzc_link_if.dev    LINK,	// command link
	output var logic   CAL_BUSY_OUT,	// calibration running
	output var logic   ZQ_CUR_EN_OUT,	// calibration current path on
	output var logic   CAL_DONE_OUT,	// one-cycle pulse: values applied
	output var logic   SELF_REF_OUT	// device in self-refresh
);
	logic             first_done;	// first long calibration done
	logic [CNT_W-1:0] cnt;	// calibration window counter
	logic             busy;
	logic             sref;
	logic             next_first_done;
	logic [CNT_W-1:0] next_cnt;
	logic             next_busy;
	logic             next_done;
	logic             next_sref;

	// next state of the calibration engine
	always_comb
	begin
		next_first_done = first_done;
		next_cnt        = cnt;
		next_busy       = busy;
		next_done       = 1'b0;
		next_sref       = sref;
		if (busy)
		begin
			// counting down the window
			if (cnt <= CNT_W'(1))
			begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
			else
			begin
				next_cnt = cnt - CNT_W'(1);
			end
		end
		else if (LINK.cmd == DZC_CMD_ZQCL)
		begin
			// long calibration, accepted only when no calibration is running
			next_busy = 1'b1;
			next_cnt  = first_done ? CNT_W'(TZQOPER_CYC) : CNT_W'(TZQINIT_CYC);
			next_first_done = 1'b1;
		end
		else if (LINK.cmd == DZC_CMD_ZQCS)
		begin
			// short calibration
			next_busy = 1'b1;
			next_cnt  = CNT_W'(TZQCS_CYC);
		end
		// self-refresh tracking; exit never starts calibration
		if (LINK.cmd == DZC_CMD_SRE)
			next_sref = 1'b1;
		else if (LINK.cmd == DZC_CMD_SRX)
			next_sref = 1'b0;
	end

	// registers
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			first_done <= 1'b0;
			cnt        <= '0;
			busy       <= 1'b0;
			sref       <= 1'b0;
		end
		else
		begin
			first_done <= next_first_done;
			cnt        <= next_cnt;
			busy       <= next_busy;
			sref       <= next_sref;
		end
	end

	// outputs from flip-flops
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			CAL_BUSY_OUT  <= 1'b0;
			ZQ_CUR_EN_OUT <= 1'b0;
			CAL_DONE_OUT  <= 1'b0;
			SELF_REF_OUT  <= 1'b0;
		end
		else
		begin
			CAL_BUSY_OUT  <= next_busy;
			ZQ_CUR_EN_OUT <= next_busy;
			CAL_DONE_OUT  <= next_done;
			SELF_REF_OUT  <= next_sref;
		end
	end
endmodule : dzc_dev
`default_nettype wire

// File: tb/dzc_monitor.sv
// link checker for calibration, refresh and self-refresh timing
`timescale 1ns/10ps
`default_nettype none
module dzc_monitor
	import dzc_pkg::*;
(
	input wire logic        CLK_IN,	// command clock
	input wire logic        RESET_N_IN,	// async reset, active low
	input wire dzc_cmd_type cmd,	// link command
	input wire logic        cke,	// clock enable
	input wire logic        odt,	// termination request
	input wire logic        dq_oe_ctl,	// controller drives data
	input wire logic [7:0]  mr2	// mode register 2 value
);
	logic [CNT_W-1:0] quiet, next_quiet;	// window cycles left
	logic [CNT_W-1:0] s_pre, next_s_pre;	// cycles since precharge
	logic [CNT_W-1:0] s_srx, next_s_srx;	// cycles since self-refresh exit
	logic [CNT_W-1:0] s_ref, next_s_ref;	// cycles since refresh
	logic             zql, next_zql;	// a long calibration was seen
	logic             cal;	// calibration command now
	assign cal = (cmd == DZC_CMD_ZQCL) || (cmd == DZC_CMD_ZQCS);
	// next helper values; counters saturate
	always_comb
	begin
		next_quiet = (quiet != 0) ? quiet - 1'b1 : quiet;
		next_s_pre = (&s_pre) ? s_pre : s_pre + 1'b1;
		next_s_srx = (&s_srx) ? s_srx : s_srx + 1'b1;
		next_s_ref = (&s_ref) ? s_ref : s_ref + 1'b1;
		next_zql = zql || (cmd == DZC_CMD_ZQCL);
		if (cmd == DZC_CMD_ZQCL)	// only the first long one gets the init window
			next_quiet = zql ? CNT_W'(TZQOPER_CYC - 1) : CNT_W'(TZQINIT_CYC - 1);
		if (cmd == DZC_CMD_ZQCS)	// short window
			next_quiet = CNT_W'(TZQCS_CYC - 1);
		if (cmd == DZC_CMD_PREA)	// restart precharge time
			next_s_pre = '0;
		if (cmd == DZC_CMD_SRX)	// restart exit time
			next_s_srx = '0;
		if (cmd == DZC_CMD_REF)	// restart refresh cycle time
			next_s_ref = '0;
	end
	// register the helpers
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			quiet <= '0;
			s_pre <= '1;
			s_srx <= '1;
			s_ref <= '1;
			zql <= 1'b0;
		end
		else
		begin
			quiet <= next_quiet;
			s_pre <= next_s_pre;
			s_srx <= next_s_srx;
			s_ref <= next_s_ref;
			zql <= next_zql;
		end
	end
	default clocking mc @(posedge CLK_IN);
	endclocking
	default disable iff (!RESET_N_IN);
	a_quiet_channel: assert property (
		(quiet != 0) |-> (cmd == DZC_CMD_NOP)) else $error("command inside calibration window");
	a_single_window: assert property (
		cal |=> (!cal) [*8]) else $error("calibration windows overlap");
	a_cke_held: assert property (
		(cal || quiet != 0) |-> cke) else $error("clock enable low while calibrating");
	a_odt_off: assert property (
		(cal || quiet != 0) |-> !odt) else $error("termination on while calibrating");
	a_dq_released: assert property (
		(cal || quiet != 0) |-> !dq_oe_ctl) else $error("data driven while calibrating");
	a_precharge_time: assert property (
		cal |-> (s_pre >= TRP_CYC - 1)) else $error("calibration too soon after precharge");
	a_srx_wait: assert property (
		cal |-> (s_srx >= TXS_CYC - 1)) else $error("calibration too soon after exit");
	a_refresh_gap: assert property (
		(cmd == DZC_CMD_REF || cmd == DZC_CMD_ACT) |-> (s_ref >= TRFC1_CYC - 1)) else $error("refresh too soon");
	a_sr_mode: assert property (
		(cmd == DZC_CMD_SRE) |-> !(mr2[MR2_ASR_BIT] && mr2[MR2_SRT_BIT])) else $error("bad self-refresh mode");
endmodule : dzc_monitor
`default_nettype wire

// File: tb/dzc_tb.sv
// self-checking bench: controller and device joined by the link
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
	$display("BAD %0t got %0h want %0h", $time, a, e); end end
module dzc_tb;
	import dzc_pkg::*;
	localparam int WL_T = 5;	// write latency used here
	logic       clk, rst_n, zqcs_req, sre_req, srx_req, ext_temp, ref1x, asr, pd_req, odt_req, dq_req;
	logic [1:0] density;	// density code
	logic       busy, init_done, odt_unc, cal_busy, zq_cur, cal_done, self_ref;
	logic [7:0] sre_mr2;	// mode bits sent with the last entry
	int         n_mismatch, comparisons, cyc, run, last_run, n_done, ref_t, ref_gap, srx_t, zq_gap;
	int         urun, ulen, n_unc, base;	// uncertainty span tracking
	int         dq_low, dq_gap;	// data release gap around a refresh
	dzc_link_if link ();
	dzc_ctl #(.NRANK(2), .WL(WL_T)) dzc_ctl_inst (.CLK_IN(clk), .RESET_N_IN(rst_n), .LINK(link),
		.ZQCS_REQ_IN(zqcs_req), .SRE_REQ_IN(sre_req), .SRX_REQ_IN(srx_req), .EXT_TEMP_IN(ext_temp),
		.REF1X_IN(ref1x), .ASR_IN(asr), .PD_REQ_IN(pd_req), .ODT_REQ_IN(odt_req), .DQ_OE_REQ_IN(dq_req),
		.DENSITY_IN(density), .BUSY_OUT(busy), .INIT_DONE_OUT(init_done), .ODT_UNCERTAIN_OUT(odt_unc));
	dzc_dev dzc_dev_inst (.CLK_IN(clk), .RESET_N_IN(rst_n), .LINK(link), .CAL_BUSY_OUT(cal_busy),
		.ZQ_CUR_EN_OUT(zq_cur), .CAL_DONE_OUT(cal_done), .SELF_REF_OUT(self_ref));
	dzc_monitor dzc_monitor_inst (.CLK_IN(clk), .RESET_N_IN(rst_n), .cmd(link.cmd), .cke(link.cke),
		.odt(link.odt), .dq_oe_ctl(link.dq_oe_ctl), .mr2(link.mr2));
	// report and stop
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	// wait for a status level, bounded
	task automatic wait_for(ref logic s, input logic v);
		for (int i = 0; i < 5000 && s !== v; i++)
			@(negedge clk);
		`CHK(s, v)
	endtask : wait_for
	// wait out one calibration and check its length
	task automatic cal_len(input int want);
		wait_for(cal_busy, 1'b1);
		wait_for(cal_busy, 1'b0);
		`CHK(zq_cur, 1'b0)
		@(negedge clk);
		`CHK(last_run, want)
	endtask : cal_len
	// free-running clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// observer of link and status, plus hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		run <= cal_busy ? run + 1 : 0;
		if (!cal_busy && run != 0)	// a calibration just ended
			last_run <= run;
		n_done <= n_done + int'(cal_done);
		dq_low <= link.dq_oe_ctl ? 0 : dq_low + 1;
		if (link.dq_oe_ctl && dq_low != 0)	// data bus handed back after a refresh
			dq_gap <= dq_low;
		urun <= odt_unc ? urun + 1 : 0;
		if (!odt_unc && urun != 0)	// an uncertain span just ended
		begin
			ulen <= urun;
			n_unc <= n_unc + 1;
		end
		if (link.cmd == DZC_CMD_REF)
		begin
			ref_gap <= cyc - ref_t;
			ref_t <= cyc;
		end
		if (link.cmd == DZC_CMD_SRE)
			sre_mr2 <= link.mr2;
		if (link.cmd == DZC_CMD_SRX)
			srx_t <= cyc;
		if (link.cmd == DZC_CMD_ZQCS)
			zq_gap <= cyc - srx_t;
		if (cyc > 30000)	// hang cut short
		begin
			n_mismatch++;
			print_verdict();
		end
	end
	// current path follows the engine
	always @(negedge clk)
		if (rst_n)
			`CHK(zq_cur, cal_busy)
	// main sequence, inputs change on falling edges
	initial
	begin
		rst_n = 1'b0;
		{zqcs_req, sre_req, srx_req, ext_temp, ref1x, asr, pd_req, odt_req, dq_req} = '0;
		density = 2'h0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		cal_len(TZQINIT_CYC);
		`CHK(last_run * CLK_PERIOD_PS >= TZQINIT_NS * 1000, 1'b1)
		cal_len(TZQOPER_CYC);
		wait_for(init_done, 1'b1);
		`CHK(n_done, 2)
		for (int k = 0; k < 3; k++)	// normal, extended, extended with 1x part
		begin
			ext_temp = (k != 0);
			ref1x = (k == 2);
			density = 2'(k);
			dq_req = 1'b1;
			repeat (2 * TREFI_NORM_CYC) @(negedge clk);
			`CHK(ref_gap <= ((k == 1) ? TREFI_EXT_CYC : TREFI_NORM_CYC), 1'b1)
			`CHK(ref_gap > ((k == 1) ? TREFI_EXT_CYC / 2 : TREFI_EXT_CYC), 1'b1)
			`CHK(dq_gap, (k == 0) ? TRFC1_CYC : ((k == 1) ? TRFC2_CYC : TRFC4_CYC))
		end
		ext_temp = 1'b0;
		odt_req = 1'b1;
		repeat (2) @(negedge clk);
		`CHK(link.odt, 1'b1)
		`CHK(link.dq_oe_ctl, 1'b1)
		{odt_req, dq_req, zqcs_req} = 3'h7;
		wait_for(busy, 1'b1);
		zqcs_req = 1'b0;
		cal_len(TZQCS_CYC);
		{odt_req, dq_req} = 2'h0;
		ext_temp = 1'b1;
		for (int a = 0; a < 2; a++)	// manual then automatic mode
		begin
			asr = a[0];
			sre_req = 1'b1;
			wait_for(self_ref, 1'b1);
			sre_req = 1'b0;
			`CHK({sre_mr2[MR2_SRT_BIT], sre_mr2[MR2_ASR_BIT]}, a ? 2'h1 : 2'h2)
			srx_req = 1'b1;
			wait_for(self_ref, 1'b0);
			srx_req = 1'b0;
			`CHK(cal_busy, 1'b0)
			cal_len(TZQCS_CYC);
			`CHK(zq_gap >= TXS_CYC, 1'b1)
		end
		wait_for(busy, 1'b0);
		base = n_unc;
		pd_req = 1'b1;
		repeat (2) @(negedge clk);
		pd_req = 1'b0;
		repeat (30) @(negedge clk);
		`CHK(n_unc, base + 1)
		`CHK(ulen > 2 * (WL_T - 1) && ulen <= 2 * (WL_T - 1) + 4, 1'b1)
		pd_req = 1'b1;
		repeat (30) @(negedge clk);
		pd_req = 1'b0;
		repeat (30) @(negedge clk);
		`CHK(n_unc, base + 3)
		print_verdict();
	end
endmodule : dzc_tb
`default_nettype wire
